/* ibl_pkg.sv */
package ibl_pkg;
    // host register select
    localparam logic SEL_STATUS = 1'b0;
    localparam logic SEL_DATA   = 1'b1;
    // status/control bit positions
    localparam int SB_SRQ = 15;
    localparam int SB_ER2 = 14;
    localparam int SB_ER1 = 13;
    localparam int SB_CMD = 10;
    localparam int SB_TKR = 9;
    localparam int SB_LNR = 8;
    localparam int SB_ACC = 7;
    localparam int SB_IE  = 6;
    localparam int SB_TON = 5;
    localparam int SB_LON = 4;
    localparam int SB_IBC = 3;
    localparam int SB_REM = 2;
    localparam int SB_EOP = 1;
    localparam int SB_TCS = 0;
    // timing
    localparam int CLK_NS       = 40;
    localparam int NRFD_HOLD_NS = 500;
    localparam int IFC_PULSE_NS = 125000;
    localparam int HOLD_CYC     = (NRFD_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int IFC_CYC      = IFC_PULSE_NS / CLK_NS;
    localparam int CNT_W        = 12;
    // interrupt vector offsets, highest priority first
    localparam logic [3:0] VEC_ERR = 4'h0;
    localparam logic [3:0] VEC_SRQ = 4'h4;
    localparam logic [3:0] VEC_CMD = 4'h8;
    localparam logic [3:0] VEC_LNR = 4'hc;
    // transmit queue
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W     = 9;
    // control lines, order equals data register bits 15..8
    typedef struct packed {
        logic eoi;
        logic atn;
        logic ifc;
        logic ren;
        logic srq;
        logic nrfd;
        logic dav;
        logic ndac;
    } ibl_lines_t;
    // queued outgoing byte
    typedef struct packed {
        logic       cmd;
        logic [7:0] dat;
    } ibl_xfer_t;
    // take-control sequencer
    typedef enum logic [4:0] {
        TC_IDLE   = 5'h01,
        TC_HOLD   = 5'h02,
        TC_WAIT   = 5'h04,
        TC_SETTLE = 5'h08,
        TC_ON     = 5'h10
    } ibl_tc_t;
    // source handshake
    typedef enum logic [3:0] {
        SR_IDLE  = 4'h1,
        SR_CHECK = 4'h2,
        SR_DAV   = 4'h4,
        SR_DONE  = 4'h8
    } ibl_src_t;
endpackage : ibl_pkg

/* ibl_fifo.sv */
`timescale 1ns/1ps
module ibl_fifo #(
    parameter int W = 9,
    parameter int D = 16
) (
    // clock, reset, enable
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    wire push = ce_i && in_valid_i && in_ready_o;
    wire pop  = ce_i && out_valid_o && out_ready_i;
    // occupancy flags
    assign in_ready_o  = cnt_q != (AW+1)'(D);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem[rp_q];
    // storage
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wp_q] <= in_data_i;
    end
    // pointers
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + AW'(1);
            if (pop)  rp_q <= rp_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ibl_fifo

/* ibl_status.sv */
// What this block does
// RULE1 - host sees only status and data registers
// RULE2 - data register: 8 data, 8 line bits
// RULE3 - high byte: EOI ATN IFC REN SRQ NRFD DAV NDAC
// RULE4 - data low byte carries commands and data
// RULE5 - control bits TALKER_READY..TAKE_CONTROL_SYNC sit at 9..0
// RULE6 - bit 15 follows low SRQ line
// RULE7 - SRQ and enable request service interrupt
// RULE8 - inhibit option makes bit 15 writable
// RULE9 - released NDAC at send sets no-acceptor error
// RULE10 - no-acceptor error clears when TALKER_FUNCTION_ON, TAKE_CONTROL_SYNC off
// RULE11 - either error with enable requests error interrupt
// RULE12 - ATN/IFC/REN mismatch sets line-conflict error when inhibit option off
// RULE13 - line conflict blocks ATN drive
// RULE14 - line-conflict error clears when mismatch gone
// RULE15 - bits 12 and 11 read zero
// RULE16 - command done after ATN or command accepted
// RULE17 - command done or talker ready interrupts
// RULE18 - command done clears on init, IFC, write, TAKE_CONTROL_SYNC
// RULE19 - talker ready on TAKE_CONTROL_SYNC off or NDAC release
// RULE20 - talker ready clears on init, IFC, write, TALKER_FUNCTION_ON, TAKE_CONTROL_SYNC
// RULE21 - interrupt enable gates all, init clears
// RULE22 - TAKE_CONTROL_SYNC holds NRFD 500 ns, ATN after DAV idle
// RULE23 - error, service, command, listener priority order
// RULE24 - talker on write-only, cleared by init, IFC
// RULE25 - init drops any pending interrupt
`timescale 1ns/1ps
module ibl_status
    import ibl_pkg::*;
(
    // clock, reset, enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // host register port
    input  wire logic        sel_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o,
    // option strap
    input  wire logic        inhibit_i,
    // instrument bus, electrical levels, low is asserted
    input  wire ibl_lines_t  lines_i,
    output ibl_lines_t       lines_o,
    output ibl_lines_t       lines_oe_o,
    input  wire logic [7:0]  dio_i,
    output logic [7:0]       dio_o,
    output logic [7:0]       dio_oe_o,
    // interrupt request
    output logic             irq_req_o,
    output logic [3:0]       irq_vec_o
);
    // pin synchronisers
    ibl_lines_t ln_s1_q;
    ibl_lines_t ln_s2_q;
    logic [7:0] dio_s1_q;
    logic [7:0] dio_s2_q;
    logic       inh_s1_q;
    logic       inh_s2_q;
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            ln_s1_q  <= '1;
            ln_s2_q  <= '1;
            dio_s1_q <= '1;
            dio_s2_q <= '1;
            inh_s1_q <= 1'b0;
            inh_s2_q <= 1'b0;
        end else if (ce_i) begin
            ln_s1_q  <= lines_i;
            ln_s2_q  <= ln_s1_q;
            dio_s1_q <= dio_i;
            dio_s2_q <= dio_s1_q;
            inh_s1_q <= inhibit_i;
            inh_s2_q <= inh_s1_q;
        end
    end
    // logical line state: one when the wire is low
    ibl_lines_t la;
    assign la = ~ln_s2_q;

    // control, flags and engines
    logic acc_q, ie_q, ton_q, lon_q, rem_q, eop_q, tcs_q, srqw_q;
    logic er1_q, er2_q, cmd_q, tkr_q, lnr_q, took_q;
    logic [7:0] rx_q;
    logic [CNT_W-1:0] ifc_cnt_q, tc_cnt_q, sr_cnt_q;
    logic [2:0] own_d1_q, own_d2_q;
    ibl_tc_t  tc_q;
    ibl_src_t sr_q;
    ibl_xfer_t cur_q;
    ibl_lines_t oe_q;

    // host decode
    wire wr_st  = ce_i && wr_i && sel_i == SEL_STATUS;
    wire wr_dat = ce_i && wr_i && sel_i == SEL_DATA;
    wire rd_dat = ce_i && rd_i && sel_i == SEL_DATA;
    wire ifc_out = ifc_cnt_q != '0;
    // received IFC is one we are not driving ourselves
    wire ifc_rx = la.ifc && !own_d2_q[1];
    wire clr_all = ifc_rx;
    wire tcs_fall = wr_st && tcs_q && !wdata_i[SB_TCS];
    wire tcs_rise = wr_st && !tcs_q && wdata_i[SB_TCS];
    wire ton_off  = wr_st && !wdata_i[SB_TON];
    wire is_cmd   = tc_q == TC_ON;

    // status view: write-only bits read zero
    wire srq_bit = inh_s2_q ? srqw_q : la.srq; // RULE6 RULE8
    wire [15:0] st_view = {srq_bit, er2_q, er1_q, 2'b00, // RULE15
                           cmd_q, tkr_q, lnr_q, 8'h00}; // RULE5
    wire [15:0] dat_view = {la, rx_q}; // RULE2 RULE3 RULE4

    // transmit queue between host writes and the source handshake
    ibl_xfer_t q_in;
    ibl_xfer_t q_out;
    logic q_rdy, q_vld;
    wire  q_take = q_vld && sr_q == SR_IDLE;
    assign q_in = '{cmd: is_cmd, dat: wdata_i[7:0]};
    ibl_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (wr_dat && (is_cmd || ton_q) && !acc_q),
        .in_ready_o  (q_rdy),
        .in_data_i   (q_in),
        .out_valid_o (q_vld),
        .out_ready_i (q_take),
        .out_data_o  (q_out)
    );

    // control bits written by software
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            {acc_q, ie_q, ton_q, lon_q} <= '0;
            {rem_q, eop_q, tcs_q, srqw_q} <= '0;
        end else if (ce_i) begin
            if (wr_st) begin // RULE1
                acc_q  <= wdata_i[SB_ACC];
                ie_q   <= wdata_i[SB_IE]; // RULE21
                ton_q  <= wdata_i[SB_TON];
                lon_q  <= wdata_i[SB_LON];
                rem_q  <= wdata_i[SB_REM];
                eop_q  <= wdata_i[SB_EOP];
                tcs_q  <= wdata_i[SB_TCS];
                srqw_q <= wdata_i[SB_SRQ]; // RULE8
            end
            if (ifc_out && ifc_cnt_q == CNT_W'(1))
                tcs_q <= 1'b1; // end of bus clear takes control
            if (clr_all) begin
                {acc_q, ton_q, lon_q} <= '0; // RULE24
                {rem_q, eop_q, tcs_q} <= '0;
            end
        end
    end

    // outgoing bus clear pulse
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            ifc_cnt_q <= '0;
        else if (ce_i) begin
            if (wr_st && wdata_i[SB_IBC])
                ifc_cnt_q <= CNT_W'(IFC_CYC);
            else if (ifc_out)
                ifc_cnt_q <= ifc_cnt_q - CNT_W'(1);
        end
    end

    // take-control sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            tc_q     <= TC_IDLE;
            tc_cnt_q <= '0;
        end else if (ce_i) begin
            if (tc_cnt_q != '0)
                tc_cnt_q <= tc_cnt_q - CNT_W'(1);
            if (!tcs_q || clr_all)
                tc_q <= TC_IDLE;
            else begin
                case (tc_q)
                    TC_IDLE:
                    begin
                        tc_q     <= TC_HOLD;
                        tc_cnt_q <= CNT_W'(HOLD_CYC - 1);
                    end
                    TC_HOLD:
                        if (tc_cnt_q == '0)
                            tc_q <= TC_WAIT; // RULE22
                    TC_WAIT:
                        if (!la.dav && !er1_q)
                        begin
                            tc_q     <= TC_SETTLE; // RULE22
                            tc_cnt_q <= CNT_W'(HOLD_CYC - 1);
                        end
                    TC_SETTLE:
                        if (tc_cnt_q == '0)
                            tc_q <= TC_ON;
                    TC_ON:
                        tc_q <= TC_ON;
                    default:
                        tc_q <= TC_IDLE;
                endcase
            end
        end
    end

    // source handshake for queued bytes
    wire src_done = sr_q == SR_DONE;
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            sr_q  <= SR_IDLE;
            cur_q <= '0;
            sr_cnt_q <= '0;
        end else if (ce_i) begin
            case (sr_q)
                SR_IDLE:
                    if (q_vld)
                    begin
                        sr_q  <= SR_CHECK;
                        cur_q <= q_out;
                        sr_cnt_q <= CNT_W'(HOLD_CYC - 1); // lines settle
                    end
                SR_CHECK:
                    if (sr_cnt_q != '0)
                        sr_cnt_q <= sr_cnt_q - CNT_W'(1);
                    else if (!la.ndac)
                        sr_q <= SR_IDLE; // no acceptor, drop byte
                    else if (!la.nrfd)
                        sr_q <= SR_DAV;
                SR_DAV:
                    if (!la.ndac)
                        sr_q <= SR_DONE;
                SR_DONE:
                    sr_q <= SR_IDLE;
                default:
                    sr_q <= SR_IDLE;
            endcase
            if (clr_all)
                sr_q <= SR_IDLE;
        end
    end

    // flag next values; hardware set wins over clear
    wire er1_now = !inh_s2_q && (own_d2_q != {la.atn, la.ifc, la.ren});
    wire er2_set = sr_q == SR_CHECK && sr_cnt_q == '0 && !la.ndac; // RULE9
    wire cmd_set = (tc_q == TC_SETTLE && tc_cnt_q == '0)
                 || (src_done && cur_q.cmd); // RULE16
    wire cmd_clr = clr_all || (wr_dat && is_cmd) || tcs_fall; // RULE18
    wire tkr_set = ((tcs_fall && wdata_i[SB_TON])
                 || (src_done && !cur_q.cmd && ton_q)) && q_rdy; // RULE19
    wire tkr_clr = clr_all || (wr_dat && !is_cmd) || ton_off
                 || tcs_rise; // RULE20
    wire lnr_set = lon_q && la.dav && !took_q && !lnr_q;
    wire lnr_clr = clr_all || (wr_st && !wdata_i[SB_LON])
                 || (acc_q ? wr_dat : rd_dat);
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            {er1_q, er2_q, cmd_q, tkr_q, lnr_q, took_q} <= '0;
            rx_q <= '0;
        end else if (ce_i) begin
            er1_q <= er1_now; // RULE12 RULE14
            er2_q <= er2_set || (er2_q && (ton_q || tcs_q)); // RULE10
            cmd_q <= cmd_set || (cmd_q && !cmd_clr);
            tkr_q <= tkr_set || (tkr_q && !tkr_clr);
            lnr_q <= lnr_set || (lnr_q && !lnr_clr);
            took_q <= lon_q && (lnr_set || (took_q && la.dav));
            if (lnr_set)
                rx_q <= ~dio_s2_q;
        end
    end

    // line drives; own ATN, IFC, REN delayed to match sync latency
    ibl_lines_t drv;
    always_comb
    begin
        drv      = '0;
        drv.atn  = (tc_q == TC_SETTLE || tc_q == TC_ON) && !er1_q; // RULE13
        drv.ifc  = ifc_out;
        drv.ren  = rem_q;
        drv.eoi  = eop_q;
        drv.nrfd = tc_q == TC_HOLD || tc_q == TC_WAIT
                 || tc_q == TC_SETTLE || lnr_q
                 || (acc_q && !tcs_q && !lon_q && !ton_q); // RULE22
        drv.dav  = sr_q == SR_DAV;
        drv.ndac = lon_q && !took_q;
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            oe_q     <= '0;
            own_d1_q <= '0;
            own_d2_q <= '0;
            dio_oe_o <= '0;
        end else if (ce_i) begin
            oe_q     <= drv;
            own_d1_q <= {oe_q.atn, oe_q.ifc, oe_q.ren};
            own_d2_q <= own_d1_q;
            dio_oe_o <= (sr_q == SR_CHECK || sr_q == SR_DAV)
                      ? cur_q.dat : 8'h00; // RULE4
        end
    end
    assign lines_o    = '0; // open drain: only ever pulls low
    assign lines_oe_o = oe_q;
    assign dio_o      = 8'h00;

    // interrupt arbitration
    wire err_any = er1_q || er2_q;
    logic       irq_d;
    logic [3:0] vec_d;
    always_comb
    begin
        irq_d = 1'b1;
        vec_d = VEC_ERR;
        if (!ie_q) // RULE21
            irq_d = 1'b0;
        else if (err_any) // RULE11 RULE23
            vec_d = VEC_ERR;
        else if (srq_bit) // RULE7
            vec_d = VEC_SRQ;
        else if (cmd_q || tkr_q) // RULE17
            vec_d = VEC_CMD;
        else if (lnr_q)
            vec_d = VEC_LNR;
        else
            irq_d = 1'b0;
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i) begin
            irq_req_o <= 1'b0; // RULE25
            irq_vec_o <= VEC_ERR;
            rdata_o   <= '0;
        end else if (ce_i) begin
            irq_req_o <= irq_d;
            irq_vec_o <= vec_d;
            if (rd_i)
                rdata_o <= (sel_i == SEL_DATA) ? dat_view : st_view;
        end
    end

    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_srq_follows: assert property ( // RULE6
        !inh_s2_q |-> st_view[SB_SRQ] == la.srq)
        else $error("status bit 15 not following SRQ");
    chk_unused_zero: assert property ( // RULE15
        st_view[12:11] == 2'b00)
        else $error("unused status bits not zero");
    chk_high_byte: assert property ( // RULE3
        dat_view[15:8] == ~ln_s2_q)
        else $error("data high byte not line state");
    chk_err_first: assert property ( // RULE11
        ce_i && ie_q && err_any |=> irq_req_o && irq_vec_o == VEC_ERR)
        else $error("error interrupt missing");
    chk_srq_irq: assert property ( // RULE7
        ce_i && ie_q && !err_any && srq_bit
        |=> irq_req_o && irq_vec_o == VEC_SRQ)
        else $error("service interrupt missing");
    chk_ie_gates: assert property ( // RULE21
        ce_i && !ie_q |=> !irq_req_o)
        else $error("interrupt while disabled");
    chk_no_atn_err: assert property ( // RULE13
        ce_i && er1_q |=> !lines_oe_o.atn)
        else $error("ATN driven during conflict");
    chk_nrfd_hold: assert property ( // RULE22
        tc_q == TC_WAIT && $past(tc_q) == TC_HOLD
        |-> lines_oe_o.nrfd && $past(tc_q, 13) == TC_HOLD)
        else $error("NRFD not held before DAV check");
    chk_er2_set: assert property ( // RULE9
        ce_i && er2_set |=> er2_q)
        else $error("no-acceptor error not set");
    chk_er2_keep: assert property ( // RULE10
        ce_i && er2_q && (ton_q || tcs_q) |=> er2_q)
        else $error("no-acceptor error cleared early");
    chk_cmd_set: assert property ( // RULE16
        ce_i && tc_q == TC_SETTLE && tc_cnt_q == '0 |=> cmd_q)
        else $error("command done not set");
    chk_tkr_clr: assert property ( // RULE20
        ce_i && tkr_clr && !tkr_set |=> !tkr_q)
        else $error("talker ready not cleared");
    cov_take_ctl: cover property (tc_q == TC_SETTLE ##1 tc_q == TC_ON);
    cov_byte_sent: cover property (sr_q == SR_DAV ##1 sr_q == SR_DONE);
    cov_no_accept: cover property (er2_set);
    cov_listen: cover property (lnr_set ##[1:20] rd_dat);
endmodule : ibl_status

/* ibl_partner.sv */
`timescale 1ns/1ps
module ibl_partner
    import ibl_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // behaviour controls
    input  wire logic       present_i,
    input  wire logic       stall_i,
    input  wire ibl_lines_t jam_i,
    // wire levels, low is asserted
    input  wire ibl_lines_t lines_i,
    input  wire logic [7:0] dio_i,
    // pull-downs and captured traffic
    output ibl_lines_t      oe_o,
    output logic [7:0]      byte_o,
    output int              count_o
);
    logic       busy_q = 1'b0;
    logic [7:0] byte_q = 8'h00;
    int         cnt_q  = 0;

    assign byte_o  = byte_q;
    assign count_o = cnt_q;

    // acceptor: take a byte on dav, drop busy once dav goes away
    always @(posedge clk_i)
    begin
        if (!present_i)
            busy_q <= 1'b0;
        else if (!busy_q && !lines_i.dav && !stall_i)
        begin
            busy_q  <= 1'b1;
            byte_q  <= ~dio_i;
            cnt_q   <= cnt_q + 1;
        end
        else if (busy_q && lines_i.dav)
            busy_q <= 1'b0;
    end

    // ndac held until accepted, nrfd while busy or stalling
    always_comb
    begin
        oe_o      = jam_i;
        oe_o.ndac = present_i & ~busy_q;
        oe_o.nrfd = present_i & (busy_q | stall_i);
    end
endmodule : ibl_partner

/* ibl_status_tb.sv */
`timescale 1ns/1ps
module ibl_status_tb
    import ibl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sel = 1'b0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic        inhibit = 1'b0;
    logic        present = 1'b1;
    logic        stall = 1'b0;
    ibl_lines_t  jam = 8'h00;
    ibl_lines_t  dut_oe;
    ibl_lines_t  par_oe;
    ibl_lines_t  wire_l;
    logic [7:0]  dio_oe;
    logic [7:0]  dio_w;
    logic        irq;
    logic [3:0]  vec;
    logic [7:0]  got_b;
    int          got_n;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;

    // open-drain wires with pull-ups
    assign wire_l = ~(dut_oe | par_oe);
    assign dio_w  = ~dio_oe;

    always #20 clk = ~clk;

    ibl_status DUT (
        .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .sel_i(sel),
        .wr_i(wr_s), .rd_i(rd_s), .wdata_i(wdata), .rdata_o(rdata),
        .inhibit_i(inhibit), .lines_i(wire_l), .lines_o(),
        .lines_oe_o(dut_oe), .dio_i(dio_w), .dio_o(), .dio_oe_o(dio_oe),
        .irq_req_o(irq), .irq_vec_o(vec));

    ibl_partner par (
        .clk_i(clk), .present_i(present), .stall_i(stall), .jam_i(jam),
        .lines_i(wire_l), .dio_i(dio_w), .oe_o(par_oe), .byte_o(got_b),
        .count_o(got_n));

    task automatic close_out();
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic s, input logic [15:0] d);
        @(posedge clk);
        sel <= s; wdata <= d; wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic s, output logic [15:0] v);
        @(posedge clk);
        sel <= s; rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask : rd

    // poll one status bit until it reaches the wanted value
    task automatic wait_st(input int b, input logic v);
        logic [15:0] r;
        for (int i = 0; i < 300; i++)
        begin
            rd(SEL_STATUS, r);
            if (r[b] === v) return;
        end
        chk(16'(r[b]), 16'(v));
    endtask : wait_st

    task automatic wait_rx(input int n);
        for (int i = 0; i < 3000 && got_n < n; i++) @(posedge clk);
        chk(16'(got_n), 16'(n));
    endtask : wait_rx

    task automatic t_reset();
        logic [15:0] r;
        rd(SEL_STATUS, r);
        chk(r, 16'h0000);
        rd(SEL_DATA, r);
        chk(16'(r[15:8]), 16'h0001);
        chk(16'({irq, vec}), 16'h0000);
    endtask : t_reset

    task automatic t_srq();
        logic [15:0] r;
        jam.srq <= 1'b1;
        wr(SEL_STATUS, 16'h0040);
        rd(SEL_STATUS, r);
        chk(16'({r[15], r[12:11]}), 16'h0004);
        chk(16'(r[12:11]), 16'h0000);
        chk(16'({irq, vec}), 16'h0014);
        wr(SEL_STATUS, 16'h0000);
        repeat (3) @(posedge clk);
        chk(16'(irq), 16'h0000);
        jam.srq <= 1'b0;
    endtask : t_srq

    task automatic t_take();
        int n = 0;
        wr(SEL_STATUS, 16'h0041);
        for (int i = 0; i < 400 && dut_oe.atn !== 1'b1; i++)
        begin
            @(posedge clk);
            if (dut_oe.nrfd === 1'b1) n++;
        end
        chk(16'(n >= HOLD_CYC), 16'h0001);
        wait_st(SB_CMD, 1'b1);
        chk(16'({irq, vec}), 16'h0018);
        wr(SEL_DATA, 16'h003f);
        wait_rx(1);
        chk(16'(got_b), 16'h003f);
        wait_st(SB_CMD, 1'b1);
    endtask : t_take

    task automatic t_talk();
        logic [15:0] r;
        wr(SEL_STATUS, 16'h0060);
        wait_st(SB_TKR, 1'b1);
        rd(SEL_STATUS, r);
        chk(16'(r[10:9]), 16'h0001);
        wr(SEL_DATA, 16'h00a5);
        wait_rx(2);
        chk(16'(got_b), 16'h00a5);
        wait_st(SB_TKR, 1'b1);
    endtask : t_talk

    // stall the acceptor, overfill the queue, then drain it
    task automatic t_fifo();
        stall <= 1'b1;
        for (int i = 0; i < 20; i++) wr(SEL_DATA, 16'(8'h10 + i));
        stall <= 1'b0;
        wait_rx(2 + FIFO_DEPTH + 1);
        repeat (200) @(posedge clk);
        chk(16'(got_n), 16'(2 + FIFO_DEPTH + 1));
        chk(16'(got_b), 16'h0020);
    endtask : t_fifo

    task automatic t_noacc();
        present <= 1'b0;
        wr(SEL_DATA, 16'h0055);
        wait_st(SB_ER2, 1'b1);
        chk(16'({irq, vec}), 16'h0010);
        wr(SEL_STATUS, 16'h0040);
        wait_st(SB_ER2, 1'b0);
        present <= 1'b1;
    endtask : t_noacc

    task automatic t_conflict();
        logic [15:0] r;
        jam.ren <= 1'b1;
        wait_st(SB_ER1, 1'b1);
        wr(SEL_STATUS, 16'h0001);
        repeat (60) @(posedge clk);
        chk(16'(dut_oe.atn), 16'h0000);
        jam.ren <= 1'b0;
        wait_st(SB_ER1, 1'b0);
        inhibit <= 1'b1;
        repeat (4) @(posedge clk);
        jam.ren <= 1'b1;
        wr(SEL_STATUS, 16'h8000);
        rd(SEL_STATUS, r);
        chk(16'({r[15], r[13]}), 16'h0002);
        jam.ren <= 1'b0;
        inhibit <= 1'b0;
    endtask : t_conflict

    task automatic t_ifc();
        logic [15:0] r;
        int n;
        wr(SEL_STATUS, 16'h0021);
        wr(SEL_STATUS, 16'h0020);
        wait_st(SB_TKR, 1'b1);
        jam.ifc <= 1'b1;
        repeat (6) @(posedge clk);
        jam.ifc <= 1'b0;
        rd(SEL_STATUS, r);
        chk(16'(r[9]), 16'h0000);
        n = got_n;
        wr(SEL_DATA, 16'h0077);
        repeat (100) @(posedge clk);
        chk(16'(got_n), 16'(n));
    endtask : t_ifc

    task automatic t_reinit();
        jam.srq <= 1'b1;
        wr(SEL_STATUS, 16'h0040);
        repeat (4) @(posedge clk);
        chk(16'(irq), 16'h0001);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(16'(irq), 16'h0000);
        jam.srq <= 1'b0;
    endtask : t_reinit

    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            num_errors++;
            close_out();
        end
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_srq();
        t_take();
        t_talk();
        t_fifo();
        t_noacc();
        t_conflict();
        t_ifc();
        t_reinit();
        close_out();
    end
endmodule : ibl_status_tb
